// [rtl/psram_seq_pkg.sv]
// Purpose: shared constants and types for the power-up and reset sequencer
// Assumes: 20 MHz system clock
// Notes: times kept in their own unit, cycle counts derived from the clock rate
package psram_seq_pkg;

  // clock rate
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_NS = 50;

  // init_wait_time, longest time, microseconds
  localparam int unsigned INIT_WAIT_US = 150;
  localparam int unsigned INIT_WAIT_CYC = (INIT_WAIT_US * (CLK_HZ / 1_000_000) > 0) ?
                                          INIT_WAIT_US * (CLK_HZ / 1_000_000) : 1;

  // power_off_hold_time, least time, microseconds, per supply variant
  localparam int unsigned POWER_OFF_HOLD_1V8_US = 30;
  localparam int unsigned POWER_OFF_HOLD_3V_US = 50;
  localparam int unsigned POWER_OFF_HOLD_1V8_CYC = POWER_OFF_HOLD_1V8_US * (CLK_HZ / 1_000_000);
  localparam int unsigned POWER_OFF_HOLD_3V_CYC = POWER_OFF_HOLD_3V_US * (CLK_HZ / 1_000_000);

  // reset pulse and select spacing, least times, nanoseconds
  localparam int unsigned RESET_PULSE_MIN_NS = 200;
  localparam int unsigned RESET_RELEASE_TO_SELECT_NS = 200;
  localparam int unsigned RESET_ASSERT_TO_SELECT_NS = 400;
  localparam int unsigned RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESET_RELEASE_TO_SELECT_CYC =
      (RESET_RELEASE_TO_SELECT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESET_ASSERT_TO_SELECT_CYC =
      (RESET_ASSERT_TO_SELECT_NS + CLK_NS - 1) / CLK_NS;

  // refresh row counter
  localparam int unsigned ROW_W = 13;
  localparam logic [12:0] ROW_RESET = 13'h0000;
  localparam int unsigned REFRESH_DIV_CYC = 4;

  // configuration register defaults
  localparam logic [15:0] CFG0_RESET = 16'h8f1f;
  localparam logic [15:0] CFG1_RESET = 16'h0002;

  // sequencer states
  typedef enum logic [2:0] {
    ST_POWER_OFF,
    ST_HOLD_RESET,
    ST_INIT_WAIT,
    ST_READY,
    ST_DEEP_PD
  } seq_state_t;

  // supply monitor levels
  typedef struct packed {
    logic above_min;
    logic above_lockout;
    logic above_rearm;
  } supply_t;

  // configuration image
  typedef struct packed {
    logic [15:0] cfg0;
    logic [15:0] cfg1;
  } cfg_t;

  // status bundle
  typedef struct packed {
    logic ready;
    logic refresh_on;
    logic deep_pd;
    logic select_ok;
    logic data_lost;
  } seq_status_t;

endpackage : psram_seq_pkg

// [rtl/psram_sync2.sv]
// Purpose: two-flop synchroniser for pin levels
// Assumes: input changes slowly relative to clk_i
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module psram_sync2 #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // two stages, reset to a safe level
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= INIT;
      q_o <= INIT;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule : psram_sync2

// [rtl/psram_cycle_timer.sv]
// Purpose: load-and-count-down timer with done level
// Assumes: load has priority over counting
// Notes: done stays high until the next load
`timescale 1ns/1ps
module psram_cycle_timer #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  input wire logic run_i,
  // status
  output logic done_o
);

  logic [W-1:0] cnt_q;

  // count down while running, stop at zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (run_i && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done_o = (cnt_q == '0) && !load_i;

endmodule : psram_cycle_timer

// [rtl/psram_powerup_reset_sequencer.sv]
// Purpose: power-up and hardware-reset sequencing of a self-refreshing pseudo-static dram
// Assumes: supply monitor levels and pins arrive asynchronously; single 20 MHz clock
// Notes: read and write transactions live elsewhere; this block gates them
// Notes on behaviour
// - after the supply is good the device finishes self-initialisation within the wait.
// - a low reset pin during power-up delays the start of the initialisation wait.
// - the device runs refresh over its array during the initialisation wait.
// - power-on init is assured only after the supply sat below the rearm level long enough.
// - a dip that stays above the lock-out level keeps the device initialised.
// - a fall to the lock-out level loses configuration and array contents.
// - a low reset pin returns the device to standby with default configuration.
// - self-refresh halts while reset is low and resumes when it goes high.
// - hardware reset returns the refresh row counter to its default value.
// - hardware reset forces the device out of deep power down.
`timescale 1ns/1ps
module psram_powerup_reset_sequencer
  import psram_seq_pkg::*;
#(
  parameter int unsigned INIT_WAIT_CYCLES = INIT_WAIT_CYC,
  parameter int unsigned POWER_OFF_HOLD_CYCLES = POWER_OFF_HOLD_1V8_CYC,
  parameter int unsigned ROW_WIDTH = ROW_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // supply monitor comparators, asynchronous
  input wire logic vcc_above_min_i,
  input wire logic vcc_above_lockout_i,
  input wire logic vcc_above_rearm_i,
  // memory bus pins from the host
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  // deep power down request from the command logic
  input wire logic dpd_enter_i,
  // configuration writes from the command logic
  input wire logic cfg_we_i,
  input wire logic cfg_sel_i,
  input wire logic [15:0] cfg_wdata_i,
  // sequencing status
  output logic ready_o,
  output logic select_accept_o,
  output logic refresh_on_o,
  output logic deep_pd_o,
  output logic data_lost_o,
  output logic pwr_init_assured_o,
  output logic [ROW_WIDTH-1:0] refresh_row_o,
  output cfg_t cfg_o,
  // pad enables for data and strobe
  output logic dq_oe_o,
  output logic rwds_oe_o
);

  localparam int unsigned TW = $clog2(INIT_WAIT_CYCLES + 1);
  localparam int unsigned PW = $clog2(POWER_OFF_HOLD_CYCLES + 1);
  localparam logic [TW-1:0] INIT_LOAD = TW'(INIT_WAIT_CYCLES);
  localparam logic [PW-1:0] HOLD_LOAD = PW'(POWER_OFF_HOLD_CYCLES);
  localparam logic [2:0] REF_DIV_LOAD = 3'(REFRESH_DIV_CYC - 1);

  seq_state_t state_q;
  seq_state_t state_d;
  supply_t sup_raw;
  supply_t sup_s;
  logic [1:0] pin_s;
  logic rst_pin_s;
  logic cs_n_s;
  logic rst_pin_prev_q;
  logic rst_fall;
  logic init_done;
  logic init_load;
  logic init_run;
  logic hold_done;
  logic below_rearm_prev_q;
  logic armed_q;
  logic [2:0] ref_div_q;
  logic ref_tick;
  logic [ROW_WIDTH-1:0] row_q;
  logic refresh_en;
  cfg_t cfg_q;

  // true while the device holds configuration: init wait, ready or deep power down
  function automatic logic powered(input seq_state_t s);
    powered = (s == ST_INIT_WAIT) || (s == ST_READY) || (s == ST_DEEP_PD);
  endfunction : powered

  assign sup_raw = '{above_min: vcc_above_min_i, above_lockout: vcc_above_lockout_i,
                     above_rearm: vcc_above_rearm_i};

  // supply levels come from an analog monitor, so synchronise
  psram_sync2 #(.W(3), .INIT(3'h0)) u_sync_sup (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(sup_raw),
    .q_o(sup_s)
  );

  // host pins synchronised; reset pin and select idle low and high
  psram_sync2 #(.W(2), .INIT(2'h1)) u_sync_pin (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i({reset_n_i, cs_n_i}),
    .q_o(pin_s)
  );
  assign rst_pin_s = pin_s[1];
  assign cs_n_s = pin_s[0];

  // edge detect on the synchronised reset pin
  // starts low like the synced pin, so leaving reset gives no false fall
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_pin_prev_q <= 1'b0;
    end else begin
      rst_pin_prev_q <= rst_pin_s;
    end
  end
  assign rst_fall = rst_pin_prev_q && !rst_pin_s;

  assign init_load = (state_q != ST_INIT_WAIT) || !rst_pin_s;
  assign init_run = (state_q == ST_INIT_WAIT);

  // initialisation wait timer
  psram_cycle_timer #(.W(TW)) u_init_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(init_load),
    .count_i(INIT_LOAD),
    .run_i(init_run),
    .done_o(init_done)
  );

  // power-off hold timing below the rearm level
  // timer leaves reset at zero: a supply never raised counts as held low long enough
  psram_cycle_timer #(.W(PW)) u_hold_timer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .load_i(sup_s.above_rearm),
    .count_i(HOLD_LOAD),
    .run_i(1'b1),
    .done_o(hold_done)
  );

  // arm flag: long enough low supply guarantees the next power-on init
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      armed_q <= 1'b0;
      below_rearm_prev_q <= 1'b0;
    end else begin
      below_rearm_prev_q <= !sup_s.above_rearm;
      if (!sup_s.above_rearm && hold_done && below_rearm_prev_q) begin
        armed_q <= 1'b1;
      end else if (state_q == ST_READY) begin
        armed_q <= 1'b0;
      end
    end
  end

  // state transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_POWER_OFF: begin
        // low reset pin holds off the wait
        if (sup_s.above_min) begin
          state_d = rst_pin_s ? ST_INIT_WAIT : ST_HOLD_RESET;
        end
      end
      ST_HOLD_RESET: begin
        if (rst_pin_s) begin
          state_d = ST_INIT_WAIT;
        end
      end
      ST_INIT_WAIT: begin
        // ready once the wait elapses
        // a low pin wins over done so a late reset restarts the wait
        if (!rst_pin_s) begin
          state_d = ST_HOLD_RESET;
        end else if (init_done) begin
          state_d = ST_READY;
        end
      end
      ST_READY: begin
        if (!rst_pin_s) begin
          state_d = ST_HOLD_RESET;
        end else if (dpd_enter_i) begin
          state_d = ST_DEEP_PD;
        end
      end
      ST_DEEP_PD: begin
        // reset pin ends deep power down
        if (!rst_pin_s) begin
          state_d = ST_HOLD_RESET;
        end
      end
      default: state_d = ST_POWER_OFF;
    endcase
    // lock-out loses everything; a shallower dip does not
    if (!sup_s.above_lockout) begin
      state_d = ST_POWER_OFF;
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_POWER_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // refresh runs in init wait and ready; halted while reset pin is low
  assign refresh_en = rst_pin_s && ((state_q == ST_INIT_WAIT) || (state_q == ST_READY));

  // refresh pacing divider, one-cycle tick
  // reload while idle so the first tick comes a full period after refresh starts
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_div_q <= REF_DIV_LOAD;
    end else if (!refresh_en) begin
      ref_div_q <= REF_DIV_LOAD;
    end else if (ref_div_q == 3'h0) begin
      ref_div_q <= REF_DIV_LOAD;
    end else begin
      ref_div_q <= ref_div_q - 3'h1;
    end
  end
  assign ref_tick = refresh_en && (ref_div_q == 3'h0);

  // row counter back to default under reset pin or power loss
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      row_q <= ROW_WIDTH'(ROW_RESET);
    end else if (!rst_pin_s || state_q == ST_POWER_OFF) begin
      row_q <= ROW_WIDTH'(ROW_RESET);
    end else if (ref_tick) begin
      row_q <= row_q + 1'b1;
    end
  end

  // configuration defaults on reset pin; and after power loss
  // writes outside ready are dropped; only in power off and hold reset would they be lost to the defaults anyway
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q <= '{cfg0: CFG0_RESET, cfg1: CFG1_RESET};
    end else if (!rst_pin_s || !powered(state_q)) begin
      cfg_q <= '{cfg0: CFG0_RESET, cfg1: CFG1_RESET};
    end else if (cfg_we_i && state_q == ST_READY) begin
      if (cfg_sel_i) begin
        cfg_q.cfg1 <= cfg_wdata_i;
      end else begin
        cfg_q.cfg0 <= cfg_wdata_i;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ready_o <= 1'b0;
      select_accept_o <= 1'b0;
      refresh_on_o <= 1'b0;
      deep_pd_o <= 1'b0;
      pwr_init_assured_o <= 1'b0;
      refresh_row_o <= '0;
      cfg_o <= '{cfg0: CFG0_RESET, cfg1: CFG1_RESET};
      dq_oe_o <= 1'b0;
      rwds_oe_o <= 1'b0;
    end else begin
      ready_o <= (state_q == ST_READY);
      select_accept_o <= (state_q == ST_READY) && rst_pin_s && !cs_n_s;
      refresh_on_o <= refresh_en;
      deep_pd_o <= (state_q == ST_DEEP_PD);
      pwr_init_assured_o <= armed_q;
      refresh_row_o <= row_q;
      cfg_o <= cfg_q;
      // pads float during reset and init; transaction logic owns them when ready
      dq_oe_o <= 1'b0;
      rwds_oe_o <= 1'b0;
    end
  end

  // data-lost flag: set by power loss or reset fall, cleared on a new select
  // set is tested first so a loss in the same cycle as a select is never dropped
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_lost_o <= 1'b1;
    end else if (rst_fall || state_q == ST_POWER_OFF) begin
      data_lost_o <= 1'b1;
    end else if (select_accept_o) begin
      data_lost_o <= 1'b0;
    end
  end

endmodule : psram_powerup_reset_sequencer

// [tb/psram_seq_chk.sv]
// Purpose: assertions on the power-up and reset sequencer ports
// Assumes: one clock; pins pass two sync flops before the state sees them
// Notes: windows of 2 to 6 cycles cover sync, state and output registers
`timescale 1ns/1ps
module psram_seq_chk
  import psram_seq_pkg::*;
#(
  parameter int unsigned INIT_WAIT_CYCLES = 20,
  parameter int unsigned ROW_WIDTH = 13
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // supply and pins
  input wire logic vcc_above_min_i,
  input wire logic vcc_above_lockout_i,
  input wire logic reset_n_i,
  // status
  input wire logic ready_o,
  input wire logic select_accept_o,
  input wire logic refresh_on_o,
  input wire logic deep_pd_o,
  input wire logic data_lost_o,
  input wire logic [ROW_WIDTH-1:0] refresh_row_o,
  input wire cfg_t cfg_o,
  input wire logic dq_oe_o,
  input wire logic rwds_oe_o
);
  localparam int unsigned LIM = INIT_WAIT_CYCLES + 8;
  logic [31:0] up_q;

  // cycles since supply good and pin high; a dip above lock-out keeps the count
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      up_q <= '0;
    end else if (!reset_n_i || !vcc_above_lockout_i) begin
      up_q <= '0;
    end else if (vcc_above_min_i && up_q < LIM) begin
      up_q <= up_q + 1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_init_min;
    $rose(ready_o) |-> up_q >= INIT_WAIT_CYCLES;
  endproperty
  a_init_min: assert property (p_init_min)
    else $error("ready before the init wait ran out");
  property p_init_max;
    (up_q == LIM - 1 && vcc_above_min_i && reset_n_i) |=> ready_o;
  endproperty
  a_init_max: assert property (p_init_max)
    else $error("init wait overran");
  property p_init_refresh;
    $rose(ready_o) |-> $past(refresh_on_o);
  endproperty
  a_init_refresh: assert property (p_init_refresh)
    else $error("no refresh during init wait");
  property p_pads_off;
    !ready_o |-> !dq_oe_o && !rwds_oe_o;
  endproperty
  a_pads_off: assert property (p_pads_off)
    else $error("pads driven while not ready");
  property p_sel_ready;
    select_accept_o |-> ready_o;
  endproperty
  a_sel_ready: assert property (p_sel_ready)
    else $error("select accepted while not ready");
  property p_rst_cfg;
    $fell(reset_n_i) |-> ##[2:6] (cfg_o == {CFG0_RESET, CFG1_RESET} && !ready_o);
  endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("config not back to defaults");
  property p_rst_halt;
    $fell(reset_n_i) |-> ##[2:6] !refresh_on_o;
  endproperty
  a_rst_halt: assert property (p_rst_halt)
    else $error("refresh still on in reset");
  property p_rst_row;
    $fell(reset_n_i) |-> ##[2:6] (refresh_row_o == ROW_WIDTH'(ROW_RESET));
  endproperty
  a_rst_row: assert property (p_rst_row)
    else $error("row counter not reset");
  property p_rst_dpd;
    $fell(reset_n_i) |-> ##[2:6] !deep_pd_o;
  endproperty
  a_rst_dpd: assert property (p_rst_dpd)
    else $error("deep power down kept through reset");
  property p_lockout;
    $fell(vcc_above_lockout_i) |-> ##[2:6] (data_lost_o && !ready_o);
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("lock-out did not drop state");

  c_ready: cover property ($rose(ready_o));
  c_dpd: cover property ($rose(deep_pd_o));
  c_lockout: cover property ($fell(vcc_above_lockout_i));
  c_select: cover property ($rose(select_accept_o));
endmodule : psram_seq_chk

bind psram_powerup_reset_sequencer psram_seq_chk #(
  .INIT_WAIT_CYCLES(INIT_WAIT_CYCLES),
  .ROW_WIDTH(ROW_WIDTH)
) u_chk (.clk_i, .reset_i, .vcc_above_min_i, .vcc_above_lockout_i, .reset_n_i,
  .ready_o, .select_accept_o, .refresh_on_o, .deep_pd_o, .data_lost_o,
  .refresh_row_o, .cfg_o, .dq_oe_o, .rwds_oe_o);

// [tb/psram_host_model.sv]
// Purpose: host controller driving reset pin and chip select
// Assumes: pins change 2 ns after the rising edge
// Notes: spacing kept in ns so a faster clock stays legal
`timescale 1ns/1ps
module psram_host_model
  import psram_seq_pkg::*;
(
  // clock
  input wire logic clk_i,
  // device status
  input wire logic ready_i,
  // pins to the device
  output logic reset_n_o,
  output logic cs_n_o
);
  time t_fall;
  time t_rise;
  logic reload_q;

  initial begin
    reset_n_o = 1'b1;
    cs_n_o = 1'b1;
    reload_q = 1'b0;
    t_fall = 0;
    t_rise = 0;
  end

  task automatic step();
    @(posedge clk_i);
    #2;
  endtask : step

  task automatic rst_low();
    step();
    reset_n_o = 1'b0;
    t_fall = $time;
    reload_q = 1'b1;
  endtask : rst_low

  task automatic rst_high();
    while ($time - t_fall < RESET_PULSE_MIN_NS) step();
    step();
    reset_n_o = 1'b1;
    t_rise = $time;
  endtask : rst_high

  task automatic select(output logic ok);
    int n;
    for (n = 0; n < 100 && ready_i !== 1'b1; n++) step();
    while ($time - t_rise < RESET_RELEASE_TO_SELECT_NS ||
           $time - t_fall < RESET_ASSERT_TO_SELECT_NS) step();
    ok = (n < 100);
    cs_n_o = 1'b0;
    repeat (2) step();
    cs_n_o = 1'b1;
    reload_q = 1'b0;
  endtask : select
endmodule : psram_host_model

// [tb/test_psram_powerup_reset_sequencer.sv]
// Purpose: directed bench for the power-up and reset sequencer
// Assumes: init wait cut to 20 cycles, hold time to 10
// Notes: inputs change 2 ns after the rising edge
`timescale 1ns/1ps
module test_psram_powerup_reset_sequencer;
  import psram_seq_pkg::*;
  localparam int unsigned INIT = 20;
  localparam int unsigned HOLD = 10;
  logic clk_i, reset_i, vmin, lockout_voltage, vrearm, rst_n, cs_n, dpd, we, sel;
  logic ready, sel_ok, refresh, dpd_o, lost, assured, dq_oe, rwds_oe;
  logic [15:0] wdata;
  logic [ROW_W-1:0] row;
  cfg_t cfg;
  int err_total;
  int n_compared;

  psram_powerup_reset_sequencer #(.INIT_WAIT_CYCLES(INIT), .POWER_OFF_HOLD_CYCLES(HOLD),
    .ROW_WIDTH(ROW_W)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
    .vcc_above_min_i(vmin), .vcc_above_lockout_i(lockout_voltage), .vcc_above_rearm_i(vrearm),
    .reset_n_i(rst_n), .cs_n_i(cs_n), .dpd_enter_i(dpd), .cfg_we_i(we),
    .cfg_sel_i(sel), .cfg_wdata_i(wdata), .ready_o(ready), .select_accept_o(sel_ok),
    .refresh_on_o(refresh), .deep_pd_o(dpd_o), .data_lost_o(lost),
    .pwr_init_assured_o(assured), .refresh_row_o(row), .cfg_o(cfg),
    .dq_oe_o(dq_oe), .rwds_oe_o(rwds_oe));
  psram_host_model u_host (.clk_i(clk_i), .ready_i(ready), .reset_n_o(rst_n),
    .cs_n_o(cs_n));

  task automatic step();
    @(posedge clk_i);
    #2;
  endtask : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic sup(input logic [2:0] v);
    step();
    {vmin, lockout_voltage, vrearm} = v;
  endtask : sup

  task automatic cfg_write(input logic s, input logic [15:0] d);
    step();
    we = 1'b1;
    sel = s;
    wdata = d;
    step();
    we = 1'b0;
    repeat (2) step();
  endtask : cfg_write

  // bounded wait for ready, noting refresh activity on the way
  task automatic wait_ready(output int unsigned n, output logic rs);
    rs = 1'b0;
    for (n = 0; ready !== 1'b1; n++) begin
      if (n > INIT + 50) begin
        err_total++;
        results();
      end
      if (refresh === 1'b1) rs = 1'b1;
      step();
    end
  endtask : wait_ready

  task automatic t_powerup();
    int unsigned n;
    logic rs;
    logic ok;
    chk(cfg, {CFG0_RESET, CFG1_RESET});
    u_host.rst_low();
    sup(3'b111);
    repeat (INIT + 10) step();
    chk(ready, 1'b0);
    u_host.rst_high();
    wait_ready(n, rs);
    chk(32'(n >= INIT && n <= INIT + 8), 32'h1);
    chk(rs, 1'b1);
    u_host.select(ok);
    chk(ok, 1'b1);
    step();
    chk(sel_ok, 1'b1);
    repeat (3) step();
    chk(lost, 1'b0);
    $display("t_powerup done");
  endtask : t_powerup

  task automatic t_reset();
    int unsigned n;
    logic rs;
    cfg_write(1'b0, 16'h1234);
    cfg_write(1'b1, 16'h00a5);
    chk(cfg, 32'h123400a5);
    step();
    dpd = 1'b1;
    step();
    dpd = 1'b0;
    repeat (3) step();
    chk(dpd_o, 1'b1);
    chk(32'(row != ROW_RESET), 32'h1);
    u_host.rst_low();
    repeat (8) step();
    chk(cfg, {CFG0_RESET, CFG1_RESET});
    chk(refresh, 1'b0);
    chk(row, ROW_RESET);
    chk(dpd_o, 1'b0);
    chk({dq_oe, rwds_oe}, 2'h0);
    chk(lost, 1'b1);
    u_host.rst_high();
    wait_ready(n, rs);
    chk(rs, 1'b1);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_supply();
    int unsigned n;
    logic rs;
    cfg_write(1'b0, 16'h4321);
    sup(3'b011);
    repeat (10) step();
    sup(3'b111);
    repeat (8) step();
    chk(ready, 1'b1);
    chk(cfg.cfg0, 16'h4321);
    sup(3'b000);
    repeat (8) step();
    chk(ready, 1'b0);
    chk(lost, 1'b1);
    chk(cfg, {CFG0_RESET, CFG1_RESET});
    cfg_write(1'b0, 16'h5555);
    chk(cfg.cfg0, CFG0_RESET);
    repeat (HOLD + 5) step();
    sup(3'b111);
    wait_ready(n, rs);
    chk(assured, 1'b1);
    chk(32'(n >= INIT), 32'h1);
    // too short below the rearm level: a pin reset is needed
    u_host.rst_low();
    sup(3'b000);
    repeat (3) step();
    sup(3'b111);
    repeat (8) step();
    chk(assured, 1'b0);
    u_host.rst_high();
    wait_ready(n, rs);
    chk(32'(n >= INIT && n <= INIT + 8), 32'h1);
    $display("t_supply done");
  endtask : t_supply

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    reset_i = 1'b1;
    {vmin, lockout_voltage, vrearm} = 3'b000;
    dpd = 1'b0;
    we = 1'b0;
    sel = 1'b0;
    wdata = 16'h0000;
    err_total = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_i);
    #2;
    reset_i = 1'b0;
    t_powerup();
    t_reset();
    t_supply();
    results();
  end
endmodule : test_psram_powerup_reset_sequencer
